// [hsar_pkg.sv]
// Package for the serial slave front end: high-speed mode entry and alert response.
// Assumes a single 200 MHz core clock; bus pins are sampled, never used as clocks.
package hsar_pkg;
   localparam int CLK_MHZ = 200;
   localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C;
   localparam logic [4:0] HS_CODE_TOP = 5'h01;
   localparam logic [4:0] BASE_ADDR_TOP = 5'h10;
   localparam int TIMEOUT_MS = 28;
   // Milliseconds to cycles; product kept inside int range
   localparam int TIMEOUT_CYC = TIMEOUT_MS * 1000 * CLK_MHZ;
   localparam int FILT_FS_NS = 50;
   localparam int FILT_HS_NS = 10;
   localparam int FILT_FS_CYC = (FILT_FS_NS * CLK_MHZ + 999) / 1000;
   localparam int FILT_HS_CYC = (FILT_HS_NS * CLK_MHZ + 999) / 1000;
   typedef enum {
      ST_IDLE, ST_ADDR, ST_ACK, ST_SEND, ST_WAIT
   } hsar_state_t;
   typedef struct packed {
      logic scl;
      logic sda;
   } hsar_bus_t;
endpackage : hsar_pkg

// [hsar_slave.sv]
// Slave logic for high-speed mode entry/exit and the alert response query.
// Assumes open-drain pins resolved outside; pins come from another domain.
// Functional notes
// - Recognise master code, leave ninth bit high, switch filters to high speed.
// - After the repeated start, normal addressing runs at up to 3.4 MHz.
// - Stop in high-speed mode returns filters to standard/fast operation.
// - Read frame to the alert response address is a broadcast query.
// - With alert pending, acknowledge query then send own slave address.
// - Arbitrate bitwise; on loss withhold acknowledge and keep alert low.
// - Own address from two select pins sampled per transaction, 1000000..1000011.
// - Abandon a stalled transaction and release the bus after 28 ms.
`timescale 1ns/10ps
`default_nettype none
module hsar_slave
   import hsar_pkg::*;
#(
   parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Address straps
   input wire logic addr_select_low_pin,
   input wire logic addr_select_high_pin,
   // Alert source and alert pin
   input wire logic alert_pending,
   input wire logic alert_clear,
   output logic alert_n_out,
   output logic alert_n_oe,
   // Status
   output logic hs_mode,
   output logic alert_won
);
   ////////////////////////////////////////////////////////////////////
   hsar_bus_t meta_q, sync_q, filt_q, prev_q;
   logic [3:0] fcnt_q;
   logic [1:0] strap_meta_q, strap_q;
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         meta_q <= '1;
         sync_q <= '1;
         strap_meta_q <= '0;
         strap_q <= '0;
      end else begin
         meta_q <= '{scl: scl_in, sda: sda_in};
         sync_q <= meta_q;
         strap_meta_q <= {addr_select_high_pin, addr_select_low_pin};
         strap_q <= strap_meta_q;
      end
   end
   logic hs_q;
   logic [3:0] flim;
   // Spike filter: shorter window in high-speed mode keeps 3.4 MHz edges
   assign flim = hs_q ? 4'(FILT_HS_CYC) : 4'(FILT_FS_CYC);
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         filt_q <= '1;
         prev_q <= '1;
         fcnt_q <= '0;
      end else begin
         prev_q <= filt_q;
         if (sync_q == filt_q) begin
            fcnt_q <= '0;
         end else if (fcnt_q >= flim) begin
            filt_q <= sync_q;
            fcnt_q <= '0;
         end else begin
            fcnt_q <= fcnt_q + 4'h1;
         end
      end
   end
   logic scl_rise, scl_fall, start_ev, stop_ev;
   assign scl_rise = filt_q.scl && !prev_q.scl;
   assign scl_fall = !filt_q.scl && prev_q.scl;
   assign start_ev = filt_q.scl && prev_q.scl && prev_q.sda && !filt_q.sda;
   assign stop_ev = filt_q.scl && prev_q.scl && !prev_q.sda && filt_q.sda;
   ////////////////////////////////////////////////////////////////////
   hsar_state_t st_q;
   logic [3:0] bit_q;
   logic [7:0] sh_q;
   logic [7:0] tx_q;
   logic [6:0] own_q;
   logic drive_q, lost_q, won_q, tout;
   logic [31:0] tcnt_q;
   assign tout = (tcnt_q >= TIMEOUT_CYCLES - 1);
   // Timeout counts only inside a transaction, so an idle bus never trips it
   always_ff @(posedge core_clk) begin
      if (!nrst || st_q == ST_IDLE || scl_fall || scl_rise) begin
         tcnt_q <= '0;
      end else if (!tout) begin
         tcnt_q <= tcnt_q + 32'h1;
      end
   end
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         hs_q <= 1'b0;
      end else if (tout) begin
         hs_q <= 1'b0;
      end else if (stop_ev) begin
         hs_q <= 1'b0;
      end else if (st_q == ST_ADDR && scl_rise && bit_q == 4'd7
                   && sh_q[6:2] == HS_CODE_TOP) begin
         hs_q <= 1'b1;
      end
   end
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         st_q <= ST_IDLE;
         bit_q <= '0;
         sh_q <= '0;
         tx_q <= '0;
         own_q <= '0;
         drive_q <= 1'b0;
         lost_q <= 1'b0;
         won_q <= 1'b0;
      end else begin
         // Clear honoured even when a start or stop lands in the same cycle
         if (alert_clear) begin
            lost_q <= 1'b0;
            won_q <= 1'b0;
         end
         if (tout) begin
            st_q <= ST_IDLE;
            drive_q <= 1'b0;
         end else if (start_ev) begin
            st_q <= ST_ADDR;
            bit_q <= '0;
            drive_q <= 1'b0;
            own_q <= {BASE_ADDR_TOP, strap_q};
         end else if (stop_ev) begin
            st_q <= ST_IDLE;
            drive_q <= 1'b0;
         end else begin
            case (st_q)
               ST_ADDR: begin
                  if (scl_rise) begin
                     sh_q <= {sh_q[6:0], filt_q.sda};
                     bit_q <= bit_q + 4'h1;
                  end else if (scl_fall && bit_q == 4'd8) begin
                     // Master code ends here: no acknowledge, ninth bit left high
                     if (sh_q == {ALERT_RESP_ADDR, 1'b1} && alert_pending
                         && !lost_q && !won_q) begin
                        st_q <= ST_ACK;
                        drive_q <= 1'b1;
                     end else begin
                        st_q <= ST_WAIT;
                     end
                  end
               end
               ST_ACK: begin
                  if (scl_fall) begin
                     st_q <= ST_SEND;
                     tx_q <= {own_q, 1'b0};
                     drive_q <= ~own_q[6];
                     bit_q <= '0;
                  end
               end
               ST_SEND: begin
                  if (scl_rise) begin
                     if (!drive_q && !filt_q.sda) begin
                        st_q <= ST_WAIT;
                        lost_q <= 1'b1;
                     end
                     bit_q <= bit_q + 4'h1;
                  end else if (scl_fall) begin
                     if (bit_q == 4'd8) begin
                        st_q <= ST_WAIT;
                        drive_q <= 1'b0;
                        won_q <= 1'b1;
                     end else begin
                        // Eighth bit is the direction bit, sent as zero
                        tx_q <= {tx_q[6:0], 1'b0};
                        drive_q <= ~tx_q[6];
                     end
                  end
               end
               ST_WAIT: drive_q <= 1'b0;
               ST_IDLE: drive_q <= 1'b0;
               default: st_q <= ST_IDLE;
            endcase
         end
      end
   end
   assign sda_out = 1'b0;
   assign sda_oe = drive_q;
   assign alert_n_out = 1'b0;
   // Alert stays low when arbitration is lost; released only on a win or when alert_pending drops
   assign alert_n_oe = alert_pending && !won_q;
   assign hs_mode = hs_q;
   assign alert_won = won_q;
   ////////////////////////////////////////////////////////////////////
   property p_stop_exit;
      @(posedge core_clk) disable iff (!nrst) stop_ev && !tout |=> !hs_q;
   endproperty
   a_stop_exit: assert property (p_stop_exit) else $error("hs kept after stop");
   property p_reset_fs;
      @(posedge core_clk) !nrst |=> !hs_q && !sda_oe;
   endproperty
   a_reset_fs: assert property (p_reset_fs) else $error("not fs after reset");
   property p_tout_release;
      @(posedge core_clk) disable iff (!nrst) tout |=> !sda_oe && !hs_q && st_q == ST_IDLE;
   endproperty
   a_tout_release: assert property (p_tout_release) else $error("bus held past timeout");
   property p_no_ack_code;
      @(posedge core_clk) disable iff (!nrst)
         st_q == ST_ADDR && sh_q[7:3] == HS_CODE_TOP && bit_q == 4'd8 && scl_fall |=> !sda_oe;
   endproperty
   a_no_ack_code: assert property (p_no_ack_code) else $error("master code acked");
   property p_lost_quiet;
      @(posedge core_clk) disable iff (!nrst) lost_q |-> !sda_oe || st_q == ST_ACK;
   endproperty
   a_lost_quiet: assert property (p_lost_quiet) else $error("drives after loss");
   property p_lost_alert;
      @(posedge core_clk) disable iff (!nrst) lost_q && alert_pending |-> alert_n_oe;
   endproperty
   a_lost_alert: assert property (p_lost_alert) else $error("alert dropped on loss");
   property p_ack_query;
      @(posedge core_clk) disable iff (!nrst)
         st_q == ST_ACK |-> sda_oe && sh_q == {ALERT_RESP_ADDR, 1'b1};
   endproperty
   a_ack_query: assert property (p_ack_query) else $error("bad query ack");
   property p_addr_msb;
      @(posedge core_clk) disable iff (!nrst)
         st_q == ST_ACK && scl_fall && !start_ev && !stop_ev && !tout |=> !sda_oe;
   endproperty
   a_addr_msb: assert property (p_addr_msb) else $error("address msb wrong");
   c_hs: cover property (@(posedge core_clk) disable iff (!nrst) $rose(hs_q));
   c_won: cover property (@(posedge core_clk) disable iff (!nrst) $rose(won_q));
   c_lost: cover property (@(posedge core_clk) disable iff (!nrst) $rose(lost_q));
endmodule : hsar_slave
`default_nettype wire

// [hsar_bus_master.sv]
// Bus master model: makes SCL and pulls SDA low.
// Assumes the bench resolves SDA as wired-AND with a pull-up.
`timescale 1ns/10ps
`default_nettype none
module hsar_bus_master
   import hsar_pkg::*;
(
   // Clock
   input wire logic core_clk,
   // Bus
   input wire logic sda_bus,
   output hsar_bus_t drv
);
   // Quarter bit in core cycles; 125 keeps the master code at 400 kHz
   int q = 125;
   initial drv = '{scl: 1'b1, sda: 1'b1};
   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
   endtask : wt
   // Start or repeated start when first is high, else stop
   task automatic cond(input logic first);
      drv.sda <= first;
      wt(q);
      drv.scl <= 1'b1;
      wt(q);
      drv.sda <= !first;
      wt(q);
      if (first) drv.scl <= 1'b0;
      wt(q);
   endtask : cond
   // Byte MSB first plus ninth bit; a one releases SDA
   task automatic xfer(input logic [7:0] o, input logic a, output logic [7:0] i,
                       output logic ak);
      logic [8:0] ov;
      logic [8:0] iv;
      ov = {o, a};
      for (int b = 8; b >= 0; b--) begin
         drv.sda <= ov[b];
         wt(q);
         drv.scl <= 1'b1;
         wt(q);
         iv[b] = sda_bus;
         wt(q);
         drv.scl <= 1'b0;
         wt(q);
      end
      i = iv[8:1];
      ak = iv[0];
   endtask : xfer
endmodule : hsar_bus_master
`default_nettype wire

// [test_hsar_slave.sv]
// Bench for high-speed entry and the alert response query.
// Assumes the master model drives the bus; straps and alert come from here.
`timescale 1ns/10ps
`default_nettype none
module test_hsar_slave
   import hsar_pkg::*;
;
   logic core_clk = 1'b0;
   logic nrst;
   logic a_lo;
   logic a_hi;
   logic pend;
   logic clr;
   wire hsar_bus_t drv;
   wire logic sda_bus;
   wire logic sda_out, sda_oe, al_out, al_oe, hs, won;
   wire logic alert_line;
   int miscompares = 0;
   int n_compared = 0;
   int cyc = 0;
   logic [7:0] rd;
   logic ak;
   always #2.5 core_clk = ~core_clk;
   // Only the low level is ever driven
   assign sda_bus = drv.sda & (sda_oe ? sda_out : 1'b1);
   // Alert line pulled up when released
   assign alert_line = al_oe ? al_out : 1'b1;
   hsar_bus_master master (.core_clk(core_clk), .sda_bus(sda_bus), .drv(drv));
   hsar_slave #(.TIMEOUT_CYCLES(2000)) DUT (.core_clk(core_clk), .nrst(nrst),
      .scl_in(drv.scl), .sda_in(sda_bus), .sda_out(sda_out), .sda_oe(sda_oe),
      .addr_select_low_pin(a_lo), .addr_select_high_pin(a_hi), .alert_pending(pend),
      .alert_clear(clr), .alert_n_out(al_out), .alert_n_oe(al_oe), .hs_mode(hs),
      .alert_won(won));
   ////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: %s seen %h want %h", $time, msg, seen, exp);
      end
   endtask : check
   task automatic report_and_stop();
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : report_and_stop
   task automatic t_hs_query();
      a_hi <= 1'b1;
      pend <= 1'b1;
      master.cond(1'b1);
      master.xfer(8'h08, 1'b1, rd, ak);
      check({6'h0, ak, hs}, 8'h03, "master code");
      master.q = 4;
      master.cond(1'b1);
      master.xfer(8'h19, 1'b1, rd, ak);
      check({7'h0, ak}, 8'h00, "query ack");
      master.xfer(8'hFF, 1'b1, rd, ak);
      check(rd, 8'h84, "own address");
      check({6'h0, won, al_oe}, 8'h02, "winner");
      check({7'h0, alert_line}, 8'h01, "winner alert released");
      master.cond(1'b0);
      master.q = 125;
      master.wt(20);
      check({7'h0, hs}, 8'h00, "stop leaves fast mode");
      $display("test hs_query finished");
   endtask : t_hs_query
   task automatic t_lose();
      a_hi <= 1'b0;
      a_lo <= 1'b1;
      clr <= 1'b1;
      master.wt(1);
      clr <= 1'b0;
      master.cond(1'b1);
      master.xfer(8'h18, 1'b1, rd, ak);
      check({7'h0, ak}, 8'h01, "write to alert address");
      master.cond(1'b1);
      master.xfer(8'h19, 1'b1, rd, ak);
      check({7'h0, ak}, 8'h00, "query after clear");
      // Competitor pulls the first address bit low
      master.xfer(8'h7F, 1'b1, rd, ak);
      check(rd, 8'h7F, "loser releases");
      check({5'h0, won, al_oe, sda_oe}, 8'h02, "loser keeps alert");
      check({7'h0, alert_line}, 8'h00, "loser alert line low");
      master.cond(1'b1);
      master.xfer(8'h19, 1'b1, rd, ak);
      check({7'h0, ak}, 8'h01, "no second answer");
      master.cond(1'b0);
      $display("test lose finished");
   endtask : t_lose
   task automatic t_timeout();
      master.cond(1'b1);
      master.xfer(8'h0F, 1'b1, rd, ak);
      check({6'h0, ak, hs}, 8'h03, "other master code");
      // SCL held low past the shortened timeout
      master.wt(2100);
      check({6'h0, hs, sda_oe}, 8'h00, "timeout recovery");
      master.cond(1'b0);
      $display("test timeout finished");
   endtask : t_timeout
   task automatic t_reset_quiet();
      pend <= 1'b0;
      clr <= 1'b1;
      master.wt(1);
      clr <= 1'b0;
      master.cond(1'b1);
      master.xfer(8'h19, 1'b1, rd, ak);
      check({6'h0, ak, al_oe}, 8'h02, "no alert no answer");
      master.cond(1'b1);
      master.xfer(8'h0A, 1'b1, rd, ak);
      check({6'h0, ak, hs}, 8'h03, "code before reset");
      // Reset in mid-frame while high-speed mode is on
      nrst <= 1'b0;
      master.wt(5);
      nrst <= 1'b1;
      master.wt(20);
      check({6'h0, hs, sda_oe}, 8'h00, "reset leaves fast mode");
      master.cond(1'b0);
      $display("test reset_quiet finished");
   endtask : t_reset_quiet
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         miscompares++;
         report_and_stop();
      end
   end
   initial begin
      nrst <= 1'b0;
      a_lo <= 1'b0;
      a_hi <= 1'b0;
      pend <= 1'b0;
      clr <= 1'b0;
      repeat (5) @(posedge core_clk);
      nrst <= 1'b1;
      master.wt(10);
      check({4'h0, hs, won, sda_oe, al_oe}, 8'h00, "reset state");
      $display("test reset finished");
      t_hs_query();
      t_lose();
      t_timeout();
      t_reset_quiet();
      report_and_stop();
   end
endmodule : test_hsar_slave
`default_nettype wire
